// File: verilog/adc_sequence_control.v
/*
 * Converter sequencing control: Avalon-MM register slave, start pulse
 * detection, channel and port split decode, interrupt status and mask.
 * Assumes analog samples arrive as 8-bit digital words from pads and that
 * software keeps start low during a conversion and re-inits after port changes.
 */
// Register access over Avalon-MM was chosen for this implementation.
// Behaviour
// - Result register read-only, D0 least significant
// - Start pulse low-high-low; convert on fall
// - Start rise resets converter, sets busy
// - Completion clears busy bit six
// - Completion sets request; interrupt needs enable
// - Bits two to zero select input
// - Bits five to three split port
// - Analog lines lose digital, pull-up; power
// - Port code zero powers converter off
// - Clock bits select divide 2/8/32
// - Clock bits two to six read zero
`include "adc_sequence_map.vh"
module adc_sequence_control #(
    parameter [7:0] CONV_PERIODS = `CONV_PERIODS
) (
    // Clock and reset
    input wire ref_clk,
    input wire reset,
    // Avalon-MM slave
    input wire [9:0] address,
    input wire read,
    input wire write,
    input wire [3:0] byteenable,
    input wire [31:0] writedata,
    output reg [31:0] readdata,
    output wire waitrequest,
    // Analog inputs, digitised by the pads
    input wire [7:0] analogIn0,
    input wire [7:0] analogIn1,
    input wire [7:0] analogIn2,
    input wire [7:0] analogIn3,
    // Port B pad control
    output reg [3:0] analogLineEn,
    output reg [3:0] digitalIoEn,
    output reg [3:0] pullUpEn,
    output reg converterPowerOn,
    // Processor interrupt
    output wire irq,
    input wire irqAccept
);

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_ARMED = 3'b010;
    localparam [2:0] ST_CONV = 3'b100;

    reg [7:0] control_ff;
    reg [7:0] clkSet_ff;
    reg [7:0] result_ff;
    reg irqStatus_ff;
    reg irqMask_ff;
    reg [2:0] state_ff;
    reg [2:0] nxt_state;
    reg respond_ff;
    reg [7:0] samp0_ff [0:3];
    reg [7:0] samp1_ff [0:3];
    reg [7:0] selSample;
    reg beginConv;
    reg abortConv;
    wire convTick;
    wire [7:0] coreValue;
    wire coreFinish;
    wire [7:0] wdByte;
    wire [7:0] regIndex;
    wire wordHit;
    wire startNew;
    wire startOld;
    wire writeCtl;

    // Index from word address; bits 1:0 of the byte address are dropped
    function [7:0] word_index;
        input [9:0] addr;
        begin
            word_index = addr[9:2];
        end
    endfunction

    // One-cycle wait state: request taken on the second edge
    assign waitrequest = (read | write) & ~respond_ff;
    assign wordHit = (read | write) & respond_ff;
    assign regIndex = word_index(address);
    assign wdByte = byteenable[0] ? writedata[7:0] : 8'h00;
    assign writeCtl = wordHit & write & byteenable[0] & (regIndex == `IDX_CONTROL);
    assign startOld = control_ff[`CTL_START_BIT];
    assign startNew = writeCtl ? writedata[`CTL_START_BIT] : startOld;

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            respond_ff <= 1'b0;
        end else begin
            respond_ff <= (read | write) & ~respond_ff;
        end
    end

    // Two-stage capture of the pad words
    always @(posedge ref_clk) begin
        samp0_ff[0] <= analogIn0;
        samp0_ff[1] <= analogIn1;
        samp0_ff[2] <= analogIn2;
        samp0_ff[3] <= analogIn3;
        samp1_ff[0] <= samp0_ff[0];
        samp1_ff[1] <= samp0_ff[1];
        samp1_ff[2] <= samp0_ff[2];
        samp1_ff[3] <= samp0_ff[3];
    end

    always @* begin
        // Undefined codes fall back to input 0
        case (control_ff[`CTL_CHAN_MSB:`CTL_CHAN_LSB])
            3'b000: selSample = samp1_ff[0];
            3'b001: selSample = samp1_ff[1];
            3'b010: selSample = samp1_ff[2];
            3'b011: selSample = samp1_ff[3];
            default: selSample = samp1_ff[0];
        endcase
    end

    // Port split and pad control
    always @* begin
        case (control_ff[`CTL_PORT_MSB:`CTL_PORT_LSB])
            3'b000: analogLineEn = 4'h0;
            3'b001: analogLineEn = 4'h1;
            3'b010: analogLineEn = 4'h3;
            3'b011: analogLineEn = 4'h7;
            default: analogLineEn = 4'hF;
        endcase
        digitalIoEn = ~analogLineEn;
        pullUpEn = ~analogLineEn;
        converterPowerOn = |analogLineEn;
    end

    // Start sequencing
    always @* begin
        nxt_state = state_ff;
        beginConv = 1'b0;
        abortConv = 1'b0;
        case (state_ff)
            ST_IDLE, ST_CONV: begin
                if (!startOld && startNew) begin
                    nxt_state = ST_ARMED;
                    abortConv = 1'b1;
                end else if (state_ff == ST_CONV && coreFinish) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_ARMED: begin
                if (!startNew) begin
                    nxt_state = ST_CONV;
                    beginConv = 1'b1;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_ff <= ST_IDLE;
            control_ff <= `RST_CONTROL;
            clkSet_ff <= `RST_CLKSET;
            result_ff <= `RST_RESULT;
            irqStatus_ff <= 1'b0;
            irqMask_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (writeCtl) begin
                control_ff[`CTL_START_BIT] <= writedata[`CTL_START_BIT];
                control_ff[`CTL_PORT_MSB:`CTL_CHAN_LSB] <= writedata[5:0];
            end
            if (abortConv) begin
                control_ff[`CTL_BUSY_BIT] <= 1'b1;
            end else if (coreFinish && state_ff == ST_CONV) begin
                control_ff[`CTL_BUSY_BIT] <= 1'b0;
            end
            if (coreFinish && state_ff == ST_CONV) begin
                result_ff <= coreValue;
            end
            if (wordHit && write && regIndex == `IDX_CLKSET && byteenable[0]) begin
                // Upper unimplemented bits are never stored
                clkSet_ff[`CLK_DIV_MSB:`CLK_DIV_LSB] <= wdByte[1:0];
                clkSet_ff[`CLK_TEST_BIT] <= wdByte[7];
            end
            if (wordHit && write && regIndex == `IDX_IRQ_MASK && byteenable[0]) begin
                irqMask_ff <= wdByte[`IRQ_DONE_BIT];
            end
            // Completion wins over a read-clear or accept in the same cycle
            if (coreFinish && state_ff == ST_CONV) begin
                irqStatus_ff <= 1'b1;
            end else if (irqAccept) begin
                irqStatus_ff <= 1'b0;
            end else if (wordHit && read && regIndex == `IDX_IRQ_STATUS) begin
                irqStatus_ff <= 1'b0;
            end else if (wordHit && write && regIndex == `IDX_IRQ_STATUS && byteenable[0]
                         && !wdByte[`IRQ_DONE_BIT]) begin
                irqStatus_ff <= 1'b0;
            end
        end
    end

    assign irq = irqStatus_ff & irqMask_ff;

    // Read data, registered into the answering cycle
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            readdata <= 32'h00000000;
        end else if (read && !respond_ff) begin
            case (regIndex)
                `IDX_RESULT: readdata <= {24'h000000, result_ff};
                `IDX_CONTROL: readdata <= {24'h000000, control_ff};
                `IDX_CLKSET: readdata <= {24'h000000, clkSet_ff[7], 5'h00,
                                          clkSet_ff[1:0]};
                `IDX_IRQ_STATUS: readdata <= {31'h00000000, irqStatus_ff};
                `IDX_IRQ_MASK: readdata <= {31'h00000000, irqMask_ff};
                default: readdata <= 32'h00000000;
            endcase
        end
    end

    conv_clock_divider u_div (
        .ref_clk(ref_clk),
        .reset(reset),
        .divCode(clkSet_ff[`CLK_DIV_MSB:`CLK_DIV_LSB]),
        .run(state_ff == ST_CONV),
        .tick_ff(convTick)
    );

    conv_core_model #(
        .PERIODS(CONV_PERIODS)
    ) u_core (
        .ref_clk(ref_clk),
        .reset(reset),
        .begin_conv(beginConv),
        .abort(abortConv),
        .tick(convTick),
        .sample(selSample),
        .value_ff(coreValue),
        .finish_ff(coreFinish)
    );

endmodule

// File: verilog/adc_sequence_map.vh
/*
 * Register map, field positions, reset values and timing counts of the
 * converter sequencing block.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef ADC_SEQUENCE_MAP_VH
`define ADC_SEQUENCE_MAP_VH

// Printed register indices; byte address is four times the index
`define IDX_RESULT 8'h21
`define IDX_CONTROL 8'h22
`define IDX_CLKSET 8'h23
`define IDX_IRQ_STATUS 8'h24
`define IDX_IRQ_MASK 8'h25

// Control register fields
`define CTL_CHAN_LSB 0
`define CTL_CHAN_MSB 2
`define CTL_PORT_LSB 3
`define CTL_PORT_MSB 5
`define CTL_BUSY_BIT 6
`define CTL_START_BIT 7

// Clock-setting register fields
`define CLK_DIV_LSB 0
`define CLK_DIV_MSB 1
`define CLK_TEST_BIT 7

// Interrupt status/mask bits
`define IRQ_DONE_BIT 0

// Reset values
`define RST_CONTROL 8'h40
`define RST_CLKSET 8'h80
`define RST_RESULT 8'h00

// Converter clock divide ratios, in system clocks
`define DIV_CODE0 8'h02
`define DIV_CODE1 8'h08
`define DIV_CODE2 8'h20

// Converter clock periods per conversion
`define CONV_PERIODS 8'h10

`endif

// File: verilog/conv_clock_divider.v
/*
 * Converter clock tick generator: one-cycle tick every ratio system clocks.
 * Assumes divCode held steady; a code change keeps the running count.
 */
module conv_clock_divider (
    // Clock and reset
    input wire ref_clk,
    input wire reset,
    // Control
    input wire [1:0] divCode,
    input wire run,
    // Tick out
    output reg tick_ff
);
`include "adc_sequence_map.vh"

    reg [7:0] count_ff;
    reg [7:0] nxt_count;
    reg nxt_tick;
    reg [7:0] ratio;

    always @* begin
        case (divCode)
            2'b00: ratio = `DIV_CODE0;
            2'b01: ratio = `DIV_CODE1;
            2'b10: ratio = `DIV_CODE2;
            // Undefined code runs at the slowest rate
            default: ratio = `DIV_CODE2;
        endcase
    end

    always @* begin
        nxt_count = 8'h00;
        nxt_tick = 1'b0;
        if (run) begin
            if (count_ff >= ratio - 8'h01) begin
                nxt_tick = 1'b1;
            end else begin
                nxt_count = count_ff + 8'h01;
            end
        end
    end

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            count_ff <= 8'h00;
            tick_ff <= 1'b0;
        end else begin
            count_ff <= nxt_count;
            tick_ff <= nxt_tick;
        end
    end
endmodule

// File: verilog/conv_core_model.v
/*
 * Digital stand-in for the successive-approximation core: counts converter
 * clock ticks and latches the sampled input at the end.
 * Assumes sample is already synchronised to ref_clk.
 */
`include "adc_sequence_map.vh"
module conv_core_model #(
    parameter [7:0] PERIODS = `CONV_PERIODS
) (
    // Clock and reset
    input wire ref_clk,
    input wire reset,
    // Control
    input wire begin_conv,
    input wire abort,
    input wire tick,
    input wire [7:0] sample,
    // Result
    output reg [7:0] value_ff,
    output reg finish_ff
);
    reg [7:0] left_ff;
    reg active_ff;

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            left_ff <= 8'h00;
            active_ff <= 1'b0;
            value_ff <= 8'h00;
            finish_ff <= 1'b0;
        end else begin
            finish_ff <= 1'b0;
            if (abort) begin
                active_ff <= 1'b0;
            end else if (begin_conv) begin
                active_ff <= 1'b1;
                left_ff <= PERIODS;
            end else if (active_ff && tick) begin
                if (left_ff <= 8'h01) begin
                    active_ff <= 1'b0;
                    value_ff <= sample;
                    finish_ff <= 1'b1;
                end else begin
                    left_ff <= left_ff - 8'h01;
                end
            end
        end
    end
endmodule

// File: tb/port_b_sources.sv
/*
 * Port B analog sources, already digitised, one 8-bit level per line.
 * Assumes the pad mode outputs of the block tell which lines are analog.
 */
module port_b_sources #(
    parameter logic [31:0] LEVELS = 32'h7E815AA5
) (
    // Clock
    input wire logic ref_clk,
    // Pad mode
    input wire logic [3:0] lineAnalog,
    // Levels
    output logic [7:0] level0,
    output logic [7:0] level1,
    output logic [7:0] level2,
    output logic [7:0] level3
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] churn_ff = 8'h00;
    // Digital lines hold no settled level, so feed a moving pattern
    always @(posedge ref_clk) begin
        churn_ff <= churn_ff + 8'h35;
    end
    assign level0 = lineAnalog[0] ? LEVELS[7:0] : churn_ff;
    assign level1 = lineAnalog[1] ? LEVELS[15:8] : ~churn_ff;
    assign level2 = lineAnalog[2] ? LEVELS[23:16] : churn_ff;
    assign level3 = lineAnalog[3] ? LEVELS[31:24] : ~churn_ff;
endmodule

// File: tb/adc_seq_checker_properties.sv
/*
 * Port-level assertions for the converter sequencing block.
 * Assumes binding to the block's top module; sees its ports only.
 */
`include "adc_sequence_map.vh"
module adc_seq_checker #(
    parameter [7:0] CONV_PERIODS = 8'h10
) (
    input wire ref_clk,
    input wire reset,
    input wire [9:0] address,
    input wire read,
    input wire write,
    input wire [3:0] byteenable,
    input wire [31:0] writedata,
    input wire [31:0] readdata,
    input wire waitrequest,
    input wire [3:0] analogLineEn,
    input wire [3:0] digitalIoEn,
    input wire [3:0] pullUpEn,
    input wire converterPowerOn,
    input wire irq,
    input wire irqAccept
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    function automatic logic [3:0] split(input logic [2:0] c);
        return c[2] ? 4'hF : 4'h7 >> (2'd3 - c[1:0]);
    endfunction
    sequence accessDone;
        waitrequest ##1 !waitrequest;
    endsequence
    sequence regWrite(logic [7:0] idx);
        write && !waitrequest && byteenable[0] && address[9:2] == idx;
    endsequence
    AST_WAIT_STATE: assert property ($rose(read || write) |-> accessDone)
        else $error("waitrequest not one wait state");
    AST_DIGITAL_OFF: assert property (digitalIoEn == ~analogLineEn)
        else $error("digital enable on analog line");
    AST_PULLUP_OFF: assert property (pullUpEn == ~analogLineEn)
        else $error("pull-up on analog line");
    AST_POWER: assert property (converterPowerOn == (analogLineEn != 4'h0))
        else $error("converter power wrong");
    AST_LINE_SPLIT: assert property (regWrite(`IDX_CONTROL) |=>
        analogLineEn == split($past(writedata[5:3])))
        else $error("port split wrong");
    AST_IRQ_HOLD: assert property (irq && !irqAccept && !write && !read |=> irq)
        else $error("request dropped on its own");
    AST_IRQ_ACCEPT: assert property (irqAccept && irq |=> !irq)
        else $error("accept did not clear request");
    AST_IRQ_MASKED: assert property (regWrite(`IDX_IRQ_MASK) ##0 !writedata[0] |=> !irq)
        else $error("masked request reaches irq");
    AST_READDATA_HOLD: assert property (!read |=> $stable(readdata))
        else $error("readdata changed without read");
endmodule

// File: tb/tb_adc_sequence_control.sv
/*
 * Register-level bench: reset values, access kinds, port split and
 * conversions on every channel and divider with interrupt paths.
 * Assumes the block, its map header and the source model are compiled first.
 */
`include "adc_sequence_map.vh"
module tb_adc_sequence_control;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [31:0] LEVELS = 32'h7E815AA5;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [9:0] address = 10'h000;
    logic read = 1'b0;
    logic write = 1'b0;
    logic irqAccept = 1'b0;
    logic [31:0] writedata = 32'h00000000;
    logic [31:0] readdata;
    logic waitrequest, irq, converterPowerOn;
    logic [7:0] analogIn0, analogIn1, analogIn2, analogIn3, q;
    logic [3:0] analogLineEn, digitalIoEn, pullUpEn;
    int badCount = 0;
    int samplesChecked = 0;

    always #5 ref_clk = ~ref_clk;

    adc_sequence_control DUT (.ref_clk(ref_clk), .reset(reset), .address(address),
        .read(read), .write(write), .byteenable(4'hF), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .analogIn0(analogIn0),
        .analogIn1(analogIn1), .analogIn2(analogIn2), .analogIn3(analogIn3),
        .analogLineEn(analogLineEn), .digitalIoEn(digitalIoEn), .pullUpEn(pullUpEn),
        .converterPowerOn(converterPowerOn), .irq(irq), .irqAccept(irqAccept));
    port_b_sources #(.LEVELS(LEVELS)) sources (.ref_clk(ref_clk),
        .lineAnalog(analogLineEn), .level0(analogIn0), .level1(analogIn1),
        .level2(analogIn2), .level3(analogIn3));

    task automatic conclude();
        $display("mismatches %0d of %0d checks", badCount, samplesChecked);
        if (badCount == 0 && samplesChecked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samplesChecked++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            badCount++;
        end
    endtask

    // Holds the request until waitrequest is seen low, giving up after 100 cycles
    task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        address <= {idx, 2'b00};
        read <= !w;
        write <= w;
        writedata <= {24'h000000, d};
        // Sampled at the rising edge itself; the answer is taken at that edge
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 100);
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
        if (n >= 100) chk("waitrequest", 8'h00, 8'h01);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] e, input string nm);
        acc(1'b0, idx, 8'h00);
        chk(nm, e, q);
    endtask

    task automatic conv(input logic [2:0] i, input logic m);
        logic [7:0] ctl;
        logic [3:0] e4;
        int n;
        ctl = {2'b00, i, 1'b0, (i[2] ? i[1:0] : i[1:0] - 2'd1)};
        e4 = i[2] ? 4'hF : 4'h7 >> (2'd3 - i[1:0]);
        acc(1'b1, `IDX_CLKSET, 8'h80 | 8'(i % 3));
        acc(1'b1, `IDX_CONTROL, ctl);
        @(negedge ref_clk);
        chk("lines", {4'h0, e4}, {4'h0, analogLineEn});
        chk("pads", {~e4, ~e4}, {digitalIoEn, pullUpEn});
        chk("power", {7'h00, i != 3'd0}, {7'h00, converterPowerOn});
        if (i != 3'd0) begin
            acc(1'b1, `IDX_CONTROL, ctl | 8'h80);
            rd(`IDX_CONTROL, ctl | 8'hC0, "busy set");
            acc(1'b1, `IDX_CONTROL, ctl);
            n = 0;
            q = 8'h40;
            while (q[6] !== 1'b0 && n < 200) begin
                acc(1'b0, `IDX_CONTROL, 8'h00);
                n++;
            end
            chk("busy clear", ctl, q);
            chk("irq", {7'h00, m}, {7'h00, irq});
            rd(`IDX_RESULT, LEVELS[ctl[1:0] * 8 +: 8], "result");
            if (i[0]) begin
                @(posedge ref_clk) irqAccept <= 1'b1;
                @(posedge ref_clk) irqAccept <= 1'b0;
                rd(`IDX_IRQ_STATUS, 8'h00, "accepted");
            end else if (m) begin
                rd(`IDX_IRQ_STATUS, 8'h01, "status");
                rd(`IDX_IRQ_STATUS, 8'h00, "read clear");
            end else begin
                acc(1'b1, `IDX_IRQ_STATUS, 8'h00);
                rd(`IDX_IRQ_STATUS, 8'h00, "write clear");
            end
            @(negedge ref_clk);
            chk("irq low", 8'h00, {7'h00, irq});
        end
    endtask

    initial begin
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        rd(`IDX_CONTROL, 8'h40, "control reset");
        rd(`IDX_CLKSET, 8'h80, "clock reset");
        acc(1'b1, `IDX_RESULT, 8'hFF);
        rd(`IDX_RESULT, 8'h00, "result write");
        acc(1'b1, `IDX_CLKSET, 8'hFD);
        rd(`IDX_CLKSET, 8'h81, "clock unused");
        rd(8'h30, 8'h00, "unmapped");
        acc(1'b1, `IDX_IRQ_MASK, 8'h01);
        for (int i = 0; i < 8; i++) conv(i[2:0], 1'b1);
        acc(1'b1, `IDX_IRQ_MASK, 8'h00);
        conv(3'd6, 1'b0);
        conclude();
    end

    initial begin
        repeat (50000) @(posedge ref_clk);
        badCount++;
        conclude();
    end
endmodule

bind adc_sequence_control adc_seq_checker #(.CONV_PERIODS(CONV_PERIODS)) props (
    .ref_clk(ref_clk), .reset(reset), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .analogLineEn(analogLineEn), .digitalIoEn(digitalIoEn),
    .pullUpEn(pullUpEn), .converterPowerOn(converterPowerOn), .irq(irq),
    .irqAccept(irqAccept));
